// >>> hdl/adcs_pkg.sv
// Function
// - Wait mode leaves conversion untouched
// - Halt disables; settle time after wakeup
// - Power-on bit low powers converter down
// - Control/status resets zero, bit 7 read-only
// - Done flag set; cleared by control/status write or high result read
// - Speed bit: 0 divides by 4, 1 by 2
// - Power-on bit starts or stops conversion
// - Channel field selects input in binary
// - Implemented channel count is a parameter
// - High result holds result bits 9..2
// - Low result: zeros above bits 1..0
// - Registers decode at consecutive indices
// - Result registers reset to zero
// - Enabled converter repeats conversions continuously
// - Channel change aborts, clears flag, restarts
// - Results overwritten by next completed conversion
// - Saturation gives all-ones, underflow zero
package adcs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [29:0] IDX_CONTROL_STATUS = 30'h0000_0070;
  localparam logic [29:0] IDX_RESULT_HIGH = 30'h0000_0071;
  localparam logic [29:0] IDX_RESULT_LOW = 30'h0000_0072;

  localparam int BIT_DONE = 7;
  localparam int BIT_SPEED = 6;
  localparam int BIT_POWER_ON = 5;
  localparam int BIT_RESERVED = 4;
  localparam int CHAN_MSB = 3;
  localparam int CHAN_LSB = 0;

  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [7:0] CSR_WRITE_MASK = 8'h7F;

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  localparam int RESULT_BITS = 10;
  localparam logic [3:0] TOP_TRIAL_IDX = 4'h9;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAKEUP_SETTLE_NS = 1000;
  // Least time: round up
  localparam int WAKEUP_SETTLE_CYC =
    (WAKEUP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SETTLE,
    ST_SAMPLE,
    ST_TRIAL
  } adcs_state_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } adcs_ahb_req_t;

  typedef struct packed {
    logic power_on;
    logic mux_enable;
    logic [3:0] input_channel_select;
    logic sample;
    logic [9:0] trial_code;
  } adcs_ana_t;

endpackage

// >>> hdl/adcs_top.sv
`timescale 1ns/10ps
`default_nettype none

module adcs_top #(
  parameter int NUM_CHANNELS = 16,
  parameter int SETTLE_CYC = adcs_pkg::WAKEUP_SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire adcs_pkg::adcs_ahb_req_t ahb_req_i,
  input wire logic [31:0] hwdata_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Low-power control
  input wire logic halt_i,
  // Analog core
  input wire logic comp_i,
  output adcs_pkg::adcs_ana_t ana_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] reg_decode(input logic [31:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr[1:0] == 2'h0) begin
      if (addr[31:2] == adcs_pkg::IDX_CONTROL_STATUS) begin
        sel = 2'h1;
      end else if (addr[31:2] == adcs_pkg::IDX_RESULT_HIGH) begin
        sel = 2'h2;
      end else if (addr[31:2] == adcs_pkg::IDX_RESULT_LOW) begin
        sel = 2'h3;
      end
    end
    return sel;
  endfunction

  // Keep or drop the bit under trial, then raise the next one
  function automatic logic [9:0] next_trial(input logic [9:0] code, input logic [3:0] idx,
                                            input logic keep);
    logic [9:0] res;
    res = code;
    res[idx] = keep;
    if (idx != 4'h0) begin
      res[idx - 4'h1] = 1'b1;
    end
    return res;
  endfunction

  // ----------------------------------------
  // Bus address phase
  // ----------------------------------------
  logic addr_take;
  logic [1:0] addr_sel;
  logic wr_pend_ff;
  logic [1:0] wr_sel_ff;
  logic csr_wr;
  logic high_rd;

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign addr_take = ahb_req_i.hsel & ahb_req_i.hready & ahb_req_i.htrans[1];
  assign addr_sel = reg_decode(ahb_req_i.haddr);
  assign csr_wr = wr_pend_ff & (wr_sel_ff == 2'h1);
  assign high_rd = addr_take & ~ahb_req_i.hwrite & (addr_sel == 2'h2);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff <= 2'h0;
    end else begin
      wr_pend_ff <= addr_take & ahb_req_i.hwrite;
      wr_sel_ff <= addr_sel;
    end
  end

  // ----------------------------------------
  // Control/status register
  // ----------------------------------------
  logic [7:0] csr_ff;
  logic [7:0] nxt_csr;
  logic done_ff;
  logic nxt_done;
  logic conv_done;
  logic chan_change;

  // Bit 7 comes from the done flag; bit 4 is stored as written
  always_comb begin
    nxt_csr = csr_ff;
    if (csr_wr) begin
      nxt_csr = hwdata_i[7:0] & adcs_pkg::CSR_WRITE_MASK;
    end
  end

  assign chan_change = csr_wr &
    (nxt_csr[adcs_pkg::CHAN_MSB:adcs_pkg::CHAN_LSB] !=
     csr_ff[adcs_pkg::CHAN_MSB:adcs_pkg::CHAN_LSB]);

  // A completion in the clearing cycle still sets the flag
  assign nxt_done = conv_done | (done_ff & ~(csr_wr | high_rd));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      csr_ff <= adcs_pkg::CSR_RESET;
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------
  // Halt and wakeup settling
  // ----------------------------------------
  // Sequencer state is read here and by the divider, so it is declared first
  adcs_pkg::adcs_state_t state_ff;
  adcs_pkg::adcs_state_t nxt_state;
  logic settle_need_ff;
  logic [15:0] settle_cnt_ff;
  logic settle_end;

  assign settle_end = (settle_cnt_ff == 16'(SETTLE_CYC - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_need_ff <= 1'b0;
    end else if (halt_i) begin
      settle_need_ff <= 1'b1;
    end else if (state_ff == adcs_pkg::ST_SETTLE && settle_end) begin
      settle_need_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_cnt_ff <= 16'h0000;
    end else if (state_ff == adcs_pkg::ST_SETTLE) begin
      settle_cnt_ff <= settle_cnt_ff + 16'h0001;
    end else begin
      settle_cnt_ff <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Converter clock
  // ----------------------------------------
  logic run;
  logic speed_change;
  logic div_clear;
  logic [1:0] div_cnt_ff;
  logic tick;

  // Halt and power-on low both stop the converter; wait mode has no
  // input here because the CPU clock keeps running through it
  assign run = csr_ff[adcs_pkg::BIT_POWER_ON] & ~halt_i;

  assign tick = csr_ff[adcs_pkg::BIT_SPEED] ? div_cnt_ff[0] :
                (div_cnt_ff == adcs_pkg::DIV4_LAST);

  // A new speed in mid-tick would cut that tick short
  assign speed_change = csr_wr &
    (nxt_csr[adcs_pkg::BIT_SPEED] != csr_ff[adcs_pkg::BIT_SPEED]);

  // Divider starts from zero on entry to sample from off, settle or a channel change, so sampling lasts a full tick
  assign div_clear = !run || chan_change || speed_change ||
                     state_ff == adcs_pkg::ST_OFF || state_ff == adcs_pkg::ST_SETTLE;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_ff <= 2'h0;
    end else if (div_clear) begin
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------
  // Successive approximation sequencer
  // ----------------------------------------
  logic [3:0] bit_idx_ff;
  logic [9:0] trial_ff;
  logic [9:0] result_ff;

  assign conv_done = (state_ff == adcs_pkg::ST_TRIAL) & tick &
                     (bit_idx_ff == 4'h0) & run & ~chan_change;

  always_comb begin
    nxt_state = state_ff;
    if (!run) begin
      nxt_state = adcs_pkg::ST_OFF;
    end else if (chan_change && !settle_need_ff) begin
      // A channel change while settling must not skip the settle time
      nxt_state = adcs_pkg::ST_SAMPLE;
    end else begin
      case (state_ff)
        adcs_pkg::ST_OFF: begin
          nxt_state = settle_need_ff ? adcs_pkg::ST_SETTLE : adcs_pkg::ST_SAMPLE;
        end
        adcs_pkg::ST_SETTLE: begin
          if (settle_end) begin
            nxt_state = adcs_pkg::ST_SAMPLE;
          end
        end
        adcs_pkg::ST_SAMPLE: begin
          if (tick) begin
            nxt_state = adcs_pkg::ST_TRIAL;
          end
        end
        adcs_pkg::ST_TRIAL: begin
          if (conv_done) begin
            nxt_state = adcs_pkg::ST_SAMPLE;
          end
        end
        default: begin
          nxt_state = adcs_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= adcs_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_idx_ff <= 4'h0;
      trial_ff <= 10'h000;
    end else if (nxt_state != adcs_pkg::ST_TRIAL) begin
      bit_idx_ff <= adcs_pkg::TOP_TRIAL_IDX;
      trial_ff <= 10'h000;
    end else if (state_ff == adcs_pkg::ST_SAMPLE) begin
      bit_idx_ff <= adcs_pkg::TOP_TRIAL_IDX;
      trial_ff <= 10'h200;
    end else if (tick) begin
      bit_idx_ff <= bit_idx_ff - 4'h1;
      trial_ff <= next_trial(trial_ff, bit_idx_ff, comp_i);
    end
  end

  // Comparator high on every trial saturates to all ones, low to zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_ff <= adcs_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result_ff <= next_trial(trial_ff, 4'h0, comp_i);
    end
  end

  // ----------------------------------------
  // Analog core controls
  // ----------------------------------------
  logic [3:0] chan_sel;

  assign chan_sel = csr_ff[adcs_pkg::CHAN_MSB:adcs_pkg::CHAN_LSB];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ana_o <= '0;
    end else begin
      // Powered through settling too, so sampling never sees an unpowered core
      ana_o.power_on <= run;
      // Unbuilt channels leave the mux open rather than alias another pin
      ana_o.mux_enable <= run & (32'(chan_sel) < NUM_CHANNELS);
      ana_o.input_channel_select <= chan_sel;
      ana_o.sample <= (nxt_state == adcs_pkg::ST_SAMPLE);
      ana_o.trial_code <= (nxt_state == adcs_pkg::ST_TRIAL && state_ff == adcs_pkg::ST_SAMPLE)
                          ? 10'h200 : trial_ff;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Built from next values so a read right behind a write sees it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_take && !ahb_req_i.hwrite) begin
      case (addr_sel)
        2'h1: hrdata_o <= {24'h00_0000, done_ff | conv_done, nxt_csr[6:0]};
        2'h2: hrdata_o <= {24'h00_0000, result_ff[9:2]};
        2'h3: hrdata_o <= {30'h0000_0000, result_ff[1:0]};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> verification/adcs_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module adcs_top_chk #(
  parameter int NUM_CHANNELS = 16
) (
  // Watched ports
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic halt_i,
  input wire adcs_pkg::adcs_ana_t ana_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // Bus, halt and mux checks; sample phase lasts at least the shortest tick
  // ----
  sequence s_smp_rise; $rose(ana_o.sample); endsequence
  sequence s_smp_held; ana_o.sample || !ana_o.power_on; endsequence
  property p_ready; hreadyout_o; endproperty
  property p_okay; !hresp_o; endproperty
  property p_rd_upper; hrdata_o[31:8] == 24'h0; endproperty
  property p_halt_off; halt_i |=> !ana_o.power_on; endproperty
  property p_halt_idle; halt_i |=> !ana_o.sample; endproperty
  property p_smp_pow; ana_o.sample |-> ana_o.power_on; endproperty
  property p_mux_chan;
    ana_o.mux_enable |-> 32'(ana_o.input_channel_select) < NUM_CHANNELS;
  endproperty
  // Shortest tick is two clocks
  property p_smp_tick; s_smp_rise |=> s_smp_held; endproperty
  a_ready: assert property (p_ready) else $error("wait state");
  a_okay: assert property (p_okay) else $error("bad resp");
  a_rd_upper: assert property (p_rd_upper) else $error("upper rdata");
  a_halt_off: assert property (p_halt_off) else $error("halt powered");
  a_halt_idle: assert property (p_halt_idle) else $error("halt sampling");
  a_smp_pow: assert property (p_smp_pow) else $error("sample unpowered");
  a_mux_chan: assert property (p_mux_chan) else $error("mux on bad chan");
  a_smp_tick: assert property (p_smp_tick) else $error("short sample");
endmodule
`default_nettype wire

// >>> verification/adcs_far.sv
`timescale 1ns/10ps
`default_nettype none
module adcs_far (
  // Converter side
  input wire logic mclk_i,
  input wire adcs_pkg::adcs_ana_t ana_i,
  input var int lvl_i [16],
  output logic comp_o
);
  logic last_ff = 1'b0;
  int v;
  // Unpowered comparator output is junk
  always_comb begin
    v = ana_i.mux_enable ? lvl_i[ana_i.input_channel_select] : 0;
    comp_o = ana_i.power_on ? v >= int'(ana_i.trial_code) : ~last_ff;
  end
  always_ff @(posedge mclk_i) last_ff <= comp_o;
endmodule
`default_nettype wire

// >>> verification/test_adc_control_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_sequencer;
  localparam int NCH = 12;
  localparam logic [31:0] A_CSR = {adcs_pkg::IDX_CONTROL_STATUS, 2'h0};
  localparam logic [31:0] A_HI = {adcs_pkg::IDX_RESULT_HIGH, 2'h0};
  localparam logic [31:0] A_LO = {adcs_pkg::IDX_RESULT_LOW, 2'h0};
  logic mclk_i = 1'b0, rst_n_i = 1'b0, sel = 1'b0, wr = 1'b0, halt = 1'b0;
  logic [1:0] tr = 2'h0;
  logic [31:0] addr = 32'h0, wd = 32'h0, seed = 32'hBE8369CC;
  logic hready, hresp, comp;
  logic [31:0] rdata, r;
  logic [7:0] w;
  int lv [16];
  int fails = 0;
  int checks = 0;
  adcs_pkg::adcs_ahb_req_t req;
  adcs_pkg::adcs_ana_t ana;
  assign req = {sel, addr, tr, wr, 3'h2, hready};
  always #2.5 mclk_i = ~mclk_i;
  adcs_top #(.NUM_CHANNELS(NCH), .SETTLE_CYC(4)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .ahb_req_i(req), .hwdata_i(wd), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(rdata), .halt_i(halt), .comp_i(comp), .ana_o(ana));
  adcs_far far (.mclk_i(mclk_i), .ana_i(ana), .lvl_i(lv), .comp_o(comp));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ----
  // Bus master
  // ----
  task automatic bus(input logic wn, input logic [31:0] a, input logic [7:0] d);
    sel <= 1'b1;
    addr <= a;
    tr <= 2'h2;
    wr <= wn;
    do @(posedge mclk_i); while (hready !== 1'b1);
    sel <= 1'b0;
    tr <= 2'h0;
    wd <= {24'h0, d};
    do @(posedge mclk_i); while (hready !== 1'b1);
    r = rdata;
  endtask
  task automatic poll();
    int k = 0;
    r = 32'h0;
    while (r[7] !== 1'b1 && k < 300) begin
      bus(1'b0, A_CSR, 8'h0);
      k++;
    end
    chk(r[7], 32'h1);
  endtask
  // Reference result from the channel level
  task automatic res(input int ch, input logic [7:0] c);
    int e;
    e = (ch >= NCH || lv[ch] < 0) ? 0 : (lv[ch] > 1023 ? 1023 : lv[ch]);
    poll();
    bus(1'b0, A_LO, 8'h0);
    chk(r, 32'(e % 4));
    bus(1'b0, A_HI, 8'h0);
    chk(r, 32'(e / 4));
    bus(1'b0, A_CSR, 8'h0);
    chk(r, {24'h0, c});
  endtask
  task automatic test_done();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk_i);
    fails++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, A_CSR + 32'(4 * i), 8'h0);
      chk(r, 32'h0);
    end
    bus(1'b1, A_CSR, 8'h80);
    bus(1'b0, A_CSR, 8'h0);
    chk(r, 32'h0);
    for (int ch = 0; ch < 16; ch++) begin
      seed = xs(seed);
      lv[ch] = int'(seed[9:0]);
      if (ch == 10) lv[ch] = 2000;
      if (ch == 11) lv[ch] = -5;
      w = {1'b0, 1'(ch % 2), 1'b1, 1'b0, 4'(ch)};
      bus(1'b1, A_CSR, w);
      res(ch, w);
      if (ch < 10) begin
        seed = xs(seed);
        lv[ch] = int'(seed[9:0]);
        poll();
        bus(1'b0, A_HI, 8'h0);
        res(ch, w);
      end
    end
    bus(1'b1, A_CSR, 8'h22);
    poll();
    bus(1'b1, A_CSR, 8'h23);
    bus(1'b0, A_CSR, 8'h0);
    chk(r, 32'h23);
    res(3, 8'h23);
    halt <= 1'b1;
    repeat (5) @(posedge mclk_i);
    bus(1'b1, A_CSR, 8'h23);
    repeat (100) @(posedge mclk_i);
    bus(1'b0, A_CSR, 8'h0);
    chk(r, 32'h23);
    halt <= 1'b0;
    res(3, 8'h23);
    bus(1'b1, A_CSR, 8'h03);
    repeat (100) @(posedge mclk_i);
    bus(1'b1, A_HI, 8'hFF);
    bus(1'b1, 32'h0000_01CC, 8'h55);
    bus(1'b0, A_CSR, 8'h0);
    chk(r, 32'h03);
    bus(1'b0, A_HI, 8'h0);
    chk(r, 32'(lv[3] / 4));
    test_done();
  end
endmodule
bind adcs_top adcs_top_chk #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .halt_i(halt_i), .ana_o(ana_o));
`default_nettype wire
